// *** design/sebfe_defs.svh ***
// Constants of the two-wire serial memory front end: codes, offsets, fields, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SEBFE_DEFS_SVH
`define SEBFE_DEFS_SVH

// Fixed device-type code in the top four bits of the device byte
`define SEBFE_DEV_CODE 4'hA
// Content of an erased location
`define SEBFE_ERASED_BYTE 8'hFF

// Timing
`define SEBFE_CLK_NS 50
`define SEBFE_T_WR_NS 5000000

// Page buffer
`define SEBFE_FIFO_DEPTH 8
`define SEBFE_FIFO_WIDTH 19

// Register byte offsets
`define SEBFE_OFS_CTRL 12'h000
`define SEBFE_OFS_STATUS 12'h004
`define SEBFE_OFS_ADDR 12'h008
`define SEBFE_OFS_COUNT 12'h00C

// Field positions
`define SEBFE_CTRL_VAR_LSB 0
`define SEBFE_CTRL_VAR_MSB 1
`define SEBFE_STAT_BUSY 0
`define SEBFE_STAT_WP 1
`define SEBFE_STAT_ACTIVE 2
`define SEBFE_STAT_FULL 3

// Reset values
`define SEBFE_CTRL_RST 2'h0
`define SEBFE_ADDR_RST 11'h000

`endif

// *** design/sebfe_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/100ps

module sebfe_fifo #(
  parameter int W = 19,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
    end else if (in_valid_i && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ptr <= '0;
    end else if (out_ready_i && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

// *** design/sebfe_pkg.sv ***
// Types shared by the serial memory front end and its page buffer.
// Assumes sebfe_defs.svh on the include path.
`include "sebfe_defs.svh"

package sebfe_pkg;

  // Capacity variants: 2K, 4K, 8K and 16K bit
  typedef enum logic [1:0] {
    VAR_2K,
    VAR_4K,
    VAR_8K,
    VAR_16K
  } sebfe_variant_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_PROG
  } sebfe_state_t;

  // One buffered write: array address and byte
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0] data;
  } sebfe_wr_t;

endpackage

// *** design/sebfe_top.sv ***
// Two-wire serial slave front end of a byte-organised nonvolatile memory.
// Assumes SCL, SDA, WP and straps arrive asynchronously and are oversampled by
// CLK_SYS_I; the array itself sits outside behind the MEM_* ports.
//
// Overview of operation
// - Start condition begins every new operation
// - SDA rising while SCL high is stop
// - Stop during read returns to standby, released
// - Stop during write launches programming cycle once a data byte was accepted
// - SDA changes with SCL high are conditions
// - Variant sets number of compared strap pins
// - Open strap pins read as low
// - Select only when strap bits match
// - Write-protect high refuses every memory write
// - SDA only pulled low or released
// - Power-on-clear resets all internal state
// - Unwritten locations read all ones
// - Receiver acknowledges on ninth clock
// - Busy programming ignores bus, no acknowledge
// - Device-type code must match first
// - Unused strap positions select 256-byte blocks
`timescale 1ns/100ps
`include "sebfe_defs.svh"

module sebfe_top #(
  parameter int unsigned WR_CYCLES = `SEBFE_T_WR_NS / `SEBFE_CLK_NS
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  input wire logic WP_I,
  input wire logic STRAP_ADDR_PIN_LO_I,
  input wire logic STRAP_ADDR_PIN_MID_I,
  input wire logic STRAP_ADDR_PIN_HI_I,
  output logic [10:0] MEM_RADDR_O,
  input wire logic [7:0] MEM_RDATA_I,
  output logic MEM_WE_O,
  input wire logic MEM_WREADY_I,
  output logic [10:0] MEM_WADDR_O,
  output logic [7:0] MEM_WDATA_O,
  output logic BUSY_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);
  localparam int TW = $clog2(WR_CYCLES + 1);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic wp_s1, wp_s2;
  logic [2:0] strap_s1, strap_s2;
  logic scl_rise, scl_fall, start_det, stop_det;

  sebfe_pkg::sebfe_state_t state;
  sebfe_pkg::sebfe_variant_t variant;
  logic [3:0] bit_cnt;
  logic [7:0] shin;
  logic [7:0] shout;
  logic rw;
  logic master_ack;
  logic sda_rel;
  logic [10:0] addr;
  logic [3:0] pend_cnt;
  logic [7:0] rdata_q;
  logic push;
  sebfe_pkg::sebfe_wr_t push_data;
  logic prog_start;
  logic prog_done;
  logic [TW-1:0] timer;
  logic [15:0] done_cnt;

  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [`SEBFE_FIFO_WIDTH-1:0] fifo_out_raw;
  sebfe_pkg::sebfe_wr_t fifo_out;

  logic [2:0] strap_mask;
  logic [2:0] blk;
  logic dev_hit;
  logic [10:0] next_page_addr;
  logic [10:0] next_seq_addr;
  logic [10:0] size_mask;
  logic [3:0] page_mask;

  logic [31:0] rd_mux;
  logic mapped;
  logic [31:0] prdata;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Open straps are pulled low on the board side; here a low pin is just 0
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      wp_s1 <= 1'b0;
      wp_s2 <= 1'b0;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      scl_s1 <= SCL_I;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= SDA_I;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      wp_s1 <= WP_I;
      wp_s2 <= wp_s1;
      strap_s1 <= {STRAP_ADDR_PIN_HI_I, STRAP_ADDR_PIN_MID_I, STRAP_ADDR_PIN_LO_I};
      strap_s2 <= strap_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  // SDA moving while SCL stays high is never data
  assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ---------------------------------------------------------------
  // Address decode per variant
  // ---------------------------------------------------------------
  always_comb begin
    unique case (variant)
      sebfe_pkg::VAR_2K: begin
        strap_mask = 3'h7;
        size_mask = 11'h0FF;
        page_mask = 4'h7;
      end
      sebfe_pkg::VAR_4K: begin
        strap_mask = 3'h6;
        size_mask = 11'h1FF;
        page_mask = 4'hF;
      end
      sebfe_pkg::VAR_8K: begin
        strap_mask = 3'h4;
        size_mask = 11'h3FF;
        page_mask = 4'hF;
      end
      sebfe_pkg::VAR_16K: begin
        strap_mask = 3'h0;
        size_mask = 11'h7FF;
        page_mask = 4'hF;
      end
    endcase
  end

  // Device byte bits 3..1 are straps where compared, block selects elsewhere
  assign dev_hit = (shin[7:4] == `SEBFE_DEV_CODE) &&
                   (((shin[3:1] ^ strap_s2) & strap_mask) == 3'h0);
  assign blk = shin[3:1] & ~strap_mask;

  // Page writes wrap inside the page; sequential reads wrap over the array
  assign next_page_addr = (addr & ~{7'h00, page_mask}) |
                          ((addr + 11'h001) & {7'h00, page_mask});
  assign next_seq_addr = (addr + 11'h001) & size_mask;

  // ---------------------------------------------------------------
  // Serial protocol engine
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state <= sebfe_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shin <= 8'h00;
      shout <= `SEBFE_ERASED_BYTE;
      rw <= 1'b0;
      master_ack <= 1'b0;
      sda_rel <= 1'b1;
      addr <= `SEBFE_ADDR_RST;
      pend_cnt <= 4'h0;
      push <= 1'b0;
      push_data <= '0;
      prog_start <= 1'b0;
    end else begin
      push <= 1'b0;
      prog_start <= 1'b0;
      if (start_det && state != sebfe_pkg::ST_PROG) begin
        state <= sebfe_pkg::ST_DEV;
        // The SCL fall that ends the start would count as a bit; wrap it to zero
        bit_cnt <= 4'hF;
        sda_rel <= 1'b1;
        pend_cnt <= 4'h0;
      end else if (stop_det && state != sebfe_pkg::ST_PROG) begin
        sda_rel <= 1'b1;
        if (state == sebfe_pkg::ST_WDATA && pend_cnt != 4'h0) begin
          state <= sebfe_pkg::ST_PROG;
          prog_start <= 1'b1;
        end else begin
          state <= sebfe_pkg::ST_IDLE;
        end
      end else if (state == sebfe_pkg::ST_PROG) begin
        if (prog_done) begin
          state <= sebfe_pkg::ST_IDLE;
        end
      end else if (state != sebfe_pkg::ST_IDLE) begin
        if (scl_rise && bit_cnt != 4'h8) begin
          shin <= {shin[6:0], sda_s2};
        end
        if (scl_rise && bit_cnt == 4'h8) begin
          master_ack <= ~sda_s2;
        end
        if (scl_fall) begin
          if (bit_cnt == 4'h7) begin
            // Ninth clock: decide on acknowledge
            bit_cnt <= 4'h8;
            sda_rel <= 1'b1;
            unique case (state)
              sebfe_pkg::ST_DEV: begin
                if (dev_hit) begin
                  sda_rel <= 1'b0;
                  rw <= shin[0];
                  addr[10:8] <= blk;
                end else begin
                  state <= sebfe_pkg::ST_IDLE;
                end
              end
              sebfe_pkg::ST_WADDR: begin
                sda_rel <= 1'b0;
                addr[7:0] <= shin;
              end
              sebfe_pkg::ST_WDATA: begin
                // Protected or full buffer: byte is dropped and left unacknowledged
                if (!wp_s2 && fifo_in_ready && pend_cnt != 4'h8) begin
                  sda_rel <= 1'b0;
                  push <= 1'b1;
                  push_data <= '{addr: addr, data: shin};
                  pend_cnt <= pend_cnt + 4'h1;
                  addr <= next_page_addr;
                end
              end
              default: begin
                sda_rel <= 1'b1;
              end
            endcase
          end else if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            sda_rel <= 1'b1;
            unique case (state)
              sebfe_pkg::ST_DEV: begin
                if (rw) begin
                  state <= sebfe_pkg::ST_RDATA;
                  shout <= rdata_q;
                  sda_rel <= rdata_q[7];
                  addr <= next_seq_addr;
                end else begin
                  state <= sebfe_pkg::ST_WADDR;
                end
              end
              sebfe_pkg::ST_WADDR: begin
                state <= sebfe_pkg::ST_WDATA;
              end
              sebfe_pkg::ST_RDATA: begin
                if (master_ack) begin
                  shout <= rdata_q;
                  sda_rel <= rdata_q[7];
                  addr <= next_seq_addr;
                end else begin
                  state <= sebfe_pkg::ST_IDLE;
                end
              end
              default: begin
                sda_rel <= 1'b1;
              end
            endcase
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state == sebfe_pkg::ST_RDATA) begin
              // Read bits change only after SCL has fallen
              shout <= {shout[6:0], 1'b1};
              sda_rel <= shout[6];
            end
          end
        end
      end
    end
  end

  // Read data is registered; the array answers well within one SCL phase
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_q <= `SEBFE_ERASED_BYTE;
    end else begin
      rdata_q <= MEM_RDATA_I;
    end
  end

  // Open drain: the pad only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_rel;
  assign MEM_RADDR_O = addr;

  // ---------------------------------------------------------------
  // Programming cycle
  // ---------------------------------------------------------------
  sebfe_fifo #(
    .W(`SEBFE_FIFO_WIDTH),
    .DEPTH(`SEBFE_FIFO_DEPTH)
  ) u_page_buf (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_raw)
  );

  assign fifo_out = sebfe_pkg::sebfe_wr_t'(fifo_out_raw);
  // Buffer drains only while programming, so the array port can stall it
  assign fifo_out_ready = (state == sebfe_pkg::ST_PROG) & MEM_WREADY_I;
  assign MEM_WE_O = (state == sebfe_pkg::ST_PROG) & fifo_out_valid;
  assign MEM_WADDR_O = fifo_out.addr;
  assign MEM_WDATA_O = fifo_out.data;

  // Busy lasts the full write time even if the array drains early
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      timer <= '0;
    end else if (prog_start) begin
      timer <= TW'(WR_CYCLES);
    end else if (timer != '0) begin
      timer <= timer - 1'b1;
    end
  end

  assign prog_done = (timer == '0) && !fifo_out_valid && !prog_start;
  assign BUSY_O = (state == sebfe_pkg::ST_PROG);

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      done_cnt <= 16'h0000;
    end else if (state == sebfe_pkg::ST_PROG && prog_done) begin
      done_cnt <= done_cnt + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // APB register slave
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (PADDR_I)
      `SEBFE_OFS_CTRL: begin
        rd_mux[`SEBFE_CTRL_VAR_MSB:`SEBFE_CTRL_VAR_LSB] = variant;
      end
      `SEBFE_OFS_STATUS: begin
        rd_mux[`SEBFE_STAT_BUSY] = BUSY_O;
        rd_mux[`SEBFE_STAT_WP] = wp_s2;
        rd_mux[`SEBFE_STAT_ACTIVE] = (state != sebfe_pkg::ST_IDLE);
        rd_mux[`SEBFE_STAT_FULL] = ~fifo_in_ready;
      end
      `SEBFE_OFS_ADDR: begin
        rd_mux[10:0] = addr;
      end
      `SEBFE_OFS_COUNT: begin
        rd_mux[15:0] = done_cnt;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read data is captured in the setup cycle, so access needs no wait state
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      prdata <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      variant <= sebfe_pkg::sebfe_variant_t'(`SEBFE_CTRL_RST);
    end else if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `SEBFE_OFS_CTRL) begin
      variant <= sebfe_pkg::sebfe_variant_t'(PWDATA_I[`SEBFE_CTRL_VAR_MSB:`SEBFE_CTRL_VAR_LSB]);
    end
  end

  assign PRDATA_O = prdata;
  assign PREADY_O = PSEL_I & PENABLE_I;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

endmodule

// *** dv/sebfe_checker.sv ***
// Port checks of the serial memory front end, bound to sebfe_top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps

module sebfe_checker #(
  parameter int unsigned WR_CYCLES = 20
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  input wire logic MEM_WE_O,
  input wire logic MEM_WREADY_I,
  input wire logic BUSY_O,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  int unsigned busy_len;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !BUSY_O) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  // ----
  // Assertions
  // ----
  open_drain_a:
    assert property (SDA_O == 1'b0) else $error("data driven high");
  reset_idle_a:
    assert property ($fell(RST_I) |-> SDA_OE_N_O && !BUSY_O && !MEM_WE_O) else $error("not idle");
  busy_on_stop_a:
    assert property ($rose(BUSY_O) |-> SCL_I && SDA_I) else $error("busy without stop");
  write_in_prog_a:
    assert property (MEM_WE_O |-> BUSY_O) else $error("array write outside busy");
  busy_silent_a:
    assert property (BUSY_O |-> SDA_OE_N_O) else $error("pull-down while busy");
  busy_time_a:
    assert property ($fell(BUSY_O) |-> busy_len >= WR_CYCLES - 1) else $error("busy too short");
  stop_release_a:
    assert property (SCL_I && $past(SCL_I) && $rose(SDA_I) |-> ##[2:6] SDA_OE_N_O [*3])
      else $error("data held after stop");
  ack_clk_low_a:
    assert property ($fell(SDA_OE_N_O) |-> !SCL_I && !$past(SCL_I)) else $error("pull with clock high");
  apb_ready_a:
    assert property (PSEL_I && PENABLE_I |-> PREADY_O) else $error("no zero-wait answer");
  apb_decode_a:
    assert property (PSEL_I && PENABLE_I && PADDR_I[1:0] == 2'h0 |->
      PSLVERR_O == (PADDR_I > 12'h00C) && (PWRITE_I || !PSLVERR_O || PRDATA_O == 32'h0000_0000))
      else $error("bad decode");
  cover property ($rose(BUSY_O));
  cover property (MEM_WE_O && MEM_WREADY_I);
  cover property ($fell(SDA_OE_N_O));
  cover property (PSLVERR_O);
endmodule

bind sebfe_top sebfe_checker #(.WR_CYCLES(WR_CYCLES)) sebfe_checker_inst (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_N_O(SDA_OE_N_O), .MEM_WE_O(MEM_WE_O), .MEM_WREADY_I(MEM_WREADY_I),
  .BUSY_O(BUSY_O), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));

// *** dv/sebfe_master.sv ***
// Two-wire bus master model: drives the serial clock and data of the front end.
// Assumes a pull-up on the data wire, whose wired level the bench feeds back.
`timescale 1ns/100ps

module sebfe_master #(
  parameter int H = 5
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1
);
  // Clock stands high between frames
  task automatic wt;
    repeat (H) @(posedge clk_i);
  endtask
  // Used only once reset has settled, so the device is initialised
  task automatic start;
    @(posedge clk_i);
    sda_o <= 1'b1;
    wt();
    scl_o <= 1'b1;
    wt();
    sda_o <= 1'b0;
    wt();
    scl_o <= 1'b0;
    wt();
  endtask
  // Data rises with the clock high
  task automatic stop;
    sda_o <= 1'b0;
    wt();
    scl_o <= 1'b1;
    wt();
    sda_o <= 1'b1;
    wt();
  endtask
  // Data changes only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    wt();
    scl_o <= 1'b1;
    wt();
    r = sda_i;
    scl_o <= 1'b0;
    wt();
  endtask
  // Eight bits MSB first, then the ninth clock for the acknowledge
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule

// *** dv/test_serial_eeprom_bus_front_end.sv ***
// Self-checking bench of the serial memory front end with random and corner transfers.
// Assumes sebfe_top with its bound checker and the master model sebfe_master.
`timescale 1ns/100ps

module test_serial_eeprom_bus_front_end;
  localparam int WRC = 400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic [2:0] strap = 3'h0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic wrdy = 1'b1;
  logic [31:0] prdata, r32;
  logic pready, pslverr, oe_n, sda_o, busy, we, ack, e;
  logic [10:0] raddr, waddr;
  logic [7:0] wdata, rd, a, d;
  logic [7:0] mem [0:2047];
  logic [7:0] exp_mem [0:255];
  logic [3:0] code;
  logic [2:0] b;
  wire scl, sda_m;
  wire sda = sda_m & (oe_n | sda_o);
  int failures = 0;
  int comparisons = 0;
  int n;
  integer seed = 32'hbea7;

  always #25 clk = ~clk;

  sebfe_top #(.WR_CYCLES(WRC)) sebfe_top_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N_O(oe_n), .WP_I(wp), .STRAP_ADDR_PIN_LO_I(strap[0]),
    .STRAP_ADDR_PIN_MID_I(strap[1]), .STRAP_ADDR_PIN_HI_I(strap[2]),
    .MEM_RADDR_O(raddr), .MEM_RDATA_I(mem[raddr]), .MEM_WE_O(we), .MEM_WREADY_I(wrdy),
    .MEM_WADDR_O(waddr), .MEM_WDATA_O(wdata), .BUSY_O(busy), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  sebfe_master sebfe_master_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  // Array stalls at random; sampled mid-cycle to stay clear of the design's edge
  always @(posedge clk) begin
    wrdy <= 1'($random(seed));
  end
  always @(negedge clk) begin
    if (we && wrdy) begin
      mem[waddr] <= wdata;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    check(pready, 1'b1);
    r32 = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  function automatic logic exp_ack(input logic [1:0] v, input logic [3:0] c,
                                   input logic [2:0] bb, input logic [2:0] s);
    logic [2:0] m;
    m = 3'h7 << v;
    return c == 4'hA && ((bb ^ s) & m) == 3'h0;
  endfunction

  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'hFF;
    end
    for (int i = 0; i < 256; i++) begin
      exp_mem[i] = 8'hFF;
    end
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    check(oe_n, 1'b1);
    check(busy, 1'b0);
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(r32, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'hFFFF_FFFF);
    check(e, 1'b1);
    // ----
    // Variants, straps and device code
    // ----
    for (int v = 3; v >= 0; v--) begin
      for (int k = 0; k < 6; k++) begin
        d = 8'($random(seed));
        strap <= d[2:0];
        b = (k == 1) ? d[2:0] : d[5:3];
        code = (k == 0) ? 4'h5 : 4'hA;
        apb(1'b1, 12'h000, 32'(v));
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(r32, 32'(v));
        sebfe_master_inst.start();
        sebfe_master_inst.tx({code, b, 1'b1}, ack);
        check(ack, exp_ack(2'(v), code, b, d[2:0]));
        if (ack) begin
          sebfe_master_inst.rx(1'b1, rd);
        end
        sebfe_master_inst.stop();
      end
    end
    // Open straps read as low, and the master sends zeros for them
    strap <= 3'h0;
    for (int t = 0; t < 3; t++) begin
      a = 8'($random(seed));
      n = (t == 0) ? 9 : 1 + {$random(seed)} % 8;
      wp <= (t == 2);
      sebfe_master_inst.start();
      sebfe_master_inst.tx(8'hA0, ack);
      check(ack, 1'b1);
      sebfe_master_inst.tx(a, ack);
      for (int i = 0; i < n; i++) begin
        d = 8'($random(seed));
        sebfe_master_inst.tx(d, ack);
        check(ack, i < 8 && t != 2);
        if (i < 8 && t != 2) begin
          exp_mem[{a[7:3], 3'(a[2:0] + i)}] = d;
        end
      end
      sebfe_master_inst.stop();
      repeat (4) @(posedge clk);
      check(busy, t != 2);
      if (t != 2) begin
        sebfe_master_inst.start();
        sebfe_master_inst.tx(8'hA1, ack);
        check(ack, 1'b0);
        sebfe_master_inst.stop();
      end
      n = 0;
      while (busy !== 1'b0 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      check(busy, 1'b0);
      a = {a[7:3], 3'h0};
      sebfe_master_inst.start();
      sebfe_master_inst.tx(8'hA0, ack);
      sebfe_master_inst.tx(a, ack);
      sebfe_master_inst.start();
      sebfe_master_inst.tx(8'hA1, ack);
      check(ack, 1'b1);
      for (int i = 0; i < 8; i++) begin
        sebfe_master_inst.rx(i == 7, rd);
        check(rd, exp_mem[8'(a + i)]);
      end
      sebfe_master_inst.stop();
    end
    // Two of the three writes above were unprotected and launched programming
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check(r32, 32'h0000_0002);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check(r32, 32'h0000_0002);
    wrap_up();
  end

  initial begin
    #3_000_000;
    failures++;
    wrap_up();
  end
endmodule
